// *** src/fpu_exc_cfg.svh ***
// register map, field positions and reset values of the exception sync block
// What this block does
// - numeric start loads instruction and operand pointers
// - masked exception gets default fix-up, continues
// - unmasked exception halts the numeric instruction
// - stack push/pop fault sets flag, invalid
// - pending error freezes before next waiting instruction in compat mode; native mode faults instead
// - no freeze on ignore input or no-wait
// - integer instructions proceed; error seen later
// - wait instruction forces pending error handling
// - handler signalled anytime before next waiting instruction
// - exception flags sticky until clear or reload
// - frozen core waits for an enabled interrupt
// - compat mode plus ignore input: continue
`ifndef FPU_EXC_CFG_SVH
`define FPU_EXC_CFG_SVH
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h1
`define REG_INSTR_PTR 4'h2
`define REG_OPND_PTR 4'h3
`define REG_IRQ_STATUS 4'h4
`define REG_IRQ_CLEAR 4'h5
`define REG_IRQ_ENABLE 4'h6
`define CTL_MASK_LSB 0
`define CTL_NATIVE_BIT 8
`define STS_STACK_FAULT_BIT 6
`define STS_PENDING_BIT 7
`define STS_FROZEN_BIT 8
`define EXC_INVALID_BIT 0
`define MASK_RESET 6'h3f
`define NATIVE_RESET 1'h0
`define IRQ_DETECT_BIT 0
`define IRQ_FREEZE_BIT 1
`define IRQ_STACK_BIT 2
`define IRQ_ENABLE_RESET 3'h0
`endif

// *** src/fpu_exc_pkg.sv ***
// types shared by the exception sync block
package fpu_exc_pkg;
    typedef enum logic [1:0] {
        CLASS_INTEGER    = 2'h0,
        CLASS_FPU_WAIT   = 2'h1,
        CLASS_FPU_NOWAIT = 2'h2,
        CLASS_WAIT       = 2'h3
    } instr_class_t;
    typedef enum logic [1:0] {
        ST_RUN    = 2'h1,
        ST_FROZEN = 2'h2
    } sync_state_t;
endpackage

// *** src/sticky_if.sv ***
// set, clear and load lines of a bank of sticky bits
`timescale 1ns/100ps
interface sticky_if #(parameter int W = 8);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic         load_en;
    logic [W-1:0] load_val;
    logic [W-1:0] q;
    modport owner (input set, input clr, input load_en, input load_val, output q);
    modport user (output set, output clr, output load_en, output load_val, input q);
endinterface

// *** src/sticky_bits.sv ***
// bank of sticky bits: a set always wins over a clear or a load
`timescale 1ns/100ps
module sticky_bits #(parameter int W = 8) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    sticky_if.owner  bits
);
    logic [W-1:0] next_q;

    always_comb begin
        next_q = bits.load_en ? bits.load_val : (bits.q & ~bits.clr);
        next_q = next_q | bits.set;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            bits.q <= '0;
        end else if (ce) begin
            bits.q <= next_q;
        end
    end
endmodule

// *** src/fpu_exception_sync_freeze.sv ***
// exception synchronisation and freeze logic of the floating-point unit
`timescale 1ns/100ps
`include "fpu_exc_cfg.svh"
module fpu_exception_sync_freeze #(
    parameter int AW    = 32,
    parameter int EXC_W = 6
) (
    input  wire logic                      core_clk,
    input  wire logic                      reset,
    input  wire logic                      ce,
    input  wire logic [3:0]                reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [31:0]                    reg_rdata,
    input  wire logic                      instr_req,
    input  wire fpu_exc_pkg::instr_class_t instr_class,
    input  wire logic [AW-1:0]             instr_addr,
    input  wire logic [AW-1:0]             instr_opnd,
    output logic                           instr_accept,
    output logic                           core_freeze,
    output logic                           native_fault,
    input  wire logic                      exc_valid,
    input  wire logic [EXC_W-1:0]          exc_raised,
    input  wire logic                      exc_stack_fault,
    output logic                           fixup_apply,
    output logic                           halt_instr,
    input  wire logic                      flags_clear,
    input  wire logic                      env_load,
    input  wire logic [EXC_W:0]            env_flags,
    input  wire logic                      ignore_numeric_error_input,
    input  wire logic                      intr_request_pin,
    input  wire logic                      core_intr_enable,
    output logic                           intr_take,
    output logic                           float_error_output_n,
    output logic                           irq
);
    // control and pointer state
    logic [EXC_W-1:0] mask;
    logic [EXC_W-1:0] next_mask;
    logic             native_error_mode_bit;
    logic             next_native;
    logic [AW-1:0]    instr_ptr;
    logic [AW-1:0]    next_instr_ptr;
    logic [AW-1:0]    opnd_ptr;
    logic [AW-1:0]    next_opnd_ptr;
    logic [2:0]       irq_enable;
    logic [2:0]       next_irq_enable;

    // pin synchronisers
    logic [2:0]       ign_sync;
    logic [2:0]       next_ign_sync;
    logic [2:0]       int_sync;
    logic [2:0]       next_int_sync;
    logic             ign_level;
    logic             next_ign_level;
    logic             int_level;
    logic             next_int_level;

    // sequencing
    fpu_exc_pkg::sync_state_t state;
    fpu_exc_pkg::sync_state_t next_state;
    logic             next_accept;
    logic             next_freeze;
    logic             next_fault;
    logic             next_take;
    logic             next_fixup;
    logic             next_halt;
    logic             next_float_error_output_n;
    logic             next_irq;
    logic             freeze_evt;
    logic [31:0]      next_rdata;

    // decode
    logic             wr_ctl;
    logic             wr_sts;
    logic             wr_irq_clr;
    logic             wr_irq_en;
    logic [EXC_W-1:0] raised;
    logic             unmasked_hit;
    logic             masked_hit;
    logic             pending;
    logic             pend_now;
    logic             busy;
    logic             waiting;
    logic             numeric;
    logic             new_req;
    logic             int_arrive;

    sticky_if #(.W(EXC_W+1)) flag_bus ();
    sticky_if #(.W(3))       irq_bus ();

    sticky_bits #(.W(EXC_W+1)) u_flags (
        .core_clk (core_clk),
        .reset    (reset),
        .ce       (ce),
        .bits     (flag_bus.owner)
    );

    sticky_bits #(.W(3)) u_irq_flags (
        .core_clk (core_clk),
        .reset    (reset),
        .ce       (ce),
        .bits     (irq_bus.owner)
    );

    assign wr_ctl     = reg_wr && (reg_addr == `REG_CONTROL);
    assign wr_sts     = reg_wr && (reg_addr == `REG_STATUS);
    assign wr_irq_clr = reg_wr && (reg_addr == `REG_IRQ_CLEAR);
    assign wr_irq_en  = reg_wr && (reg_addr == `REG_IRQ_ENABLE);

    // a stack slot fault is reported as an invalid operation
    assign raised = exc_raised | (EXC_W'(exc_stack_fault) << `EXC_INVALID_BIT);
    assign masked_hit   = exc_valid && |(raised & mask);
    assign unmasked_hit = exc_valid && |(raised & ~mask);
    assign pending      = |(flag_bus.q[EXC_W-1:0] & ~mask);
    // a detection in the same cycle as the check already counts
    assign pend_now     = pending | unmasked_hit;
    // the core drops its request one cycle after an answer
    assign busy     = instr_accept | native_fault | intr_take;
    assign waiting  = (instr_class == fpu_exc_pkg::CLASS_FPU_WAIT)
                   || (instr_class == fpu_exc_pkg::CLASS_WAIT);
    assign numeric  = (instr_class == fpu_exc_pkg::CLASS_FPU_WAIT)
                   || (instr_class == fpu_exc_pkg::CLASS_FPU_NOWAIT);
    assign new_req  = instr_req && !busy && (state == fpu_exc_pkg::ST_RUN);
    assign int_arrive = int_level && core_intr_enable;

    // flag bank: all raised bits are recorded, masked or not
    assign flag_bus.set      = exc_valid ? {exc_stack_fault, raised} : '0;
    assign flag_bus.clr      = flags_clear ? '1 : '0;
    assign flag_bus.load_en  = env_load || wr_sts;
    assign flag_bus.load_val = env_load ? env_flags : reg_wdata[EXC_W:0];

    assign irq_bus.set      = {exc_valid && exc_stack_fault, freeze_evt, unmasked_hit};
    assign irq_bus.clr      = wr_irq_clr ? reg_wdata[2:0] : 3'h0;
    assign irq_bus.load_en  = 1'b0;
    assign irq_bus.load_val = 3'h0;

    // synchronisers: a level counts once stages two and three agree
    always_comb begin
        next_ign_sync  = {ign_sync[1:0], ignore_numeric_error_input};
        next_int_sync  = {int_sync[1:0], intr_request_pin};
        next_ign_level = (ign_sync[1] == ign_sync[2]) ? ign_sync[2] : ign_level;
        next_int_level = (int_sync[1] == int_sync[2]) ? int_sync[2] : int_level;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ign_sync  <= 3'h0;
            int_sync  <= 3'h0;
            ign_level <= 1'b0;
            int_level <= 1'b0;
        end else if (ce) begin
            ign_sync  <= next_ign_sync;
            int_sync  <= next_int_sync;
            ign_level <= next_ign_level;
            int_level <= next_int_level;
        end
    end

    // control registers and context pointers
    always_comb begin
        next_mask       = mask;
        next_native     = native_error_mode_bit;
        next_instr_ptr  = instr_ptr;
        next_opnd_ptr   = opnd_ptr;
        next_irq_enable = irq_enable;
        if (wr_ctl) begin
            next_mask   = reg_wdata[`CTL_MASK_LSB +: EXC_W];
            next_native = reg_wdata[`CTL_NATIVE_BIT];
        end
        if (wr_irq_en) begin
            next_irq_enable = reg_wdata[2:0];
        end
        if (new_req && numeric && next_accept) begin
            next_instr_ptr = instr_addr;
            next_opnd_ptr  = instr_opnd;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mask                  <= `MASK_RESET;
            native_error_mode_bit <= `NATIVE_RESET;
            instr_ptr             <= '0;
            opnd_ptr              <= '0;
            irq_enable            <= `IRQ_ENABLE_RESET;
        end else if (ce) begin
            mask                  <= next_mask;
            native_error_mode_bit <= next_native;
            instr_ptr             <= next_instr_ptr;
            opnd_ptr              <= next_opnd_ptr;
            irq_enable            <= next_irq_enable;
        end
    end

    // instruction gate and freeze sequencing
    always_comb begin
        next_state  = state;
        next_accept = 1'b0;
        next_fault  = 1'b0;
        next_take   = 1'b0;
        freeze_evt  = 1'b0;
        case (state)
            fpu_exc_pkg::ST_RUN: begin
                if (new_req) begin
                    if (waiting && pend_now && native_error_mode_bit) begin
                        next_fault = 1'b1;
                    end else if (waiting && pend_now && !ign_level) begin
                        next_state = fpu_exc_pkg::ST_FROZEN;
                        freeze_evt = 1'b1;
                    end else begin
                        // integer, no-wait, or ignored error
                        next_accept = 1'b1;
                    end
                end
            end
            fpu_exc_pkg::ST_FROZEN: begin
                if (int_arrive) begin
                    next_state = fpu_exc_pkg::ST_RUN;
                    next_take  = 1'b1;
                end
            end
            default: begin
                next_state = fpu_exc_pkg::ST_RUN;
            end
        endcase
        next_freeze = (next_state == fpu_exc_pkg::ST_FROZEN);
        next_fixup  = masked_hit;
        next_halt   = unmasked_hit;
        // error output only in compatibility reporting mode
        next_float_error_output_n = !(pending && !native_error_mode_bit);
        next_irq    = |(irq_bus.q & irq_enable);
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state                <= fpu_exc_pkg::ST_RUN;
            instr_accept         <= 1'b0;
            core_freeze          <= 1'b0;
            native_fault         <= 1'b0;
            intr_take            <= 1'b0;
            fixup_apply          <= 1'b0;
            halt_instr           <= 1'b0;
            float_error_output_n <= 1'b1;
            irq                  <= 1'b0;
        end else if (ce) begin
            state                <= next_state;
            instr_accept         <= next_accept;
            core_freeze          <= next_freeze;
            native_fault         <= next_fault;
            intr_take            <= next_take;
            fixup_apply          <= next_fixup;
            halt_instr           <= next_halt;
            float_error_output_n <= next_float_error_output_n;
            irq                  <= next_irq;
        end
    end

    // register read port: data stand only in the cycle after the strobe
    always_comb begin
        next_rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `REG_CONTROL: begin
                    next_rdata = 32'({native_error_mode_bit, 2'h0, mask});
                end
                `REG_STATUS: begin
                    next_rdata = 32'({core_freeze, pending, flag_bus.q});
                end
                `REG_INSTR_PTR: begin
                    next_rdata = 32'(instr_ptr);
                end
                `REG_OPND_PTR: begin
                    next_rdata = 32'(opnd_ptr);
                end
                `REG_IRQ_STATUS: begin
                    next_rdata = 32'(irq_bus.q);
                end
                `REG_IRQ_ENABLE: begin
                    next_rdata = 32'(irq_enable);
                end
                default: begin
                    next_rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h0;
        end else if (ce) begin
            reg_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_ptr_update;
        ce && new_req && (instr_class == fpu_exc_pkg::CLASS_FPU_NOWAIT)
        |=> instr_accept && (instr_ptr == $past(instr_addr))
            && (opnd_ptr == $past(instr_opnd));
    endproperty
    a_ptr_update: assert property (p_ptr_update) else $error("pointers not loaded");

    property p_fixup;
        ce && masked_hit |=> fixup_apply;
    endproperty
    a_fixup: assert property (p_fixup) else $error("masked fix-up missing");

    property p_halt;
        ce && unmasked_hit && !wr_ctl && !flags_clear |=> halt_instr && pending;
    endproperty
    a_halt: assert property (p_halt) else $error("unmasked halt missing");

    property p_stack;
        ce && exc_valid && exc_stack_fault
        |=> flag_bus.q[`STS_STACK_FAULT_BIT] && flag_bus.q[`EXC_INVALID_BIT];
    endproperty
    a_stack: assert property (p_stack) else $error("stack fault not flagged");

    property p_freeze;
        ce && new_req && waiting && pending && !native_error_mode_bit && !ign_level
        |=> core_freeze && !instr_accept;
    endproperty
    a_freeze: assert property (p_freeze) else $error("no freeze on pending error");

    property p_ignore;
        ce && new_req && pend_now && !native_error_mode_bit && ign_level
        |=> instr_accept && !core_freeze;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignore input not honoured");

    property p_nowait;
        ce && new_req && (instr_class == fpu_exc_pkg::CLASS_FPU_NOWAIT)
        |=> instr_accept ##1 !core_freeze;
    endproperty
    a_nowait: assert property (p_nowait) else $error("no-wait form frozen");

    property p_integer;
        ce && new_req && (instr_class == fpu_exc_pkg::CLASS_INTEGER) |=> instr_accept;
    endproperty
    a_integer: assert property (p_integer) else $error("integer instruction held");

    property p_wait_native;
        ce && new_req && (instr_class == fpu_exc_pkg::CLASS_WAIT) && pend_now
        && native_error_mode_bit |=> native_fault && !instr_accept;
    endproperty
    a_wait_native: assert property (p_wait_native) else $error("wait passed error");

    property p_sticky;
        ce && flag_bus.q[`EXC_INVALID_BIT] && !flags_clear && !env_load && !wr_sts
        |=> flag_bus.q[`EXC_INVALID_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without clear");

    property p_hold_frozen;
        ce && (state == fpu_exc_pkg::ST_FROZEN) && !int_arrive |=> core_freeze && !intr_take;
    endproperty
    a_hold_frozen: assert property (p_hold_frozen) else $error("left freeze early");

    property p_release;
        ce && (state == fpu_exc_pkg::ST_FROZEN) && int_arrive |=> intr_take && !core_freeze;
    endproperty
    a_release: assert property (p_release) else $error("freeze not released");

    property p_float_error_output;
        ce |=> float_error_output_n == !($past(pending) && !$past(native_error_mode_bit));
    endproperty
    a_float_error_output: assert property (p_float_error_output) else $error("error output wrong");

    c_freeze_release: cover property (core_freeze ##[1:20] intr_take);
    c_fixup: cover property (fixup_apply);
    c_native_fault: cover property (native_fault);
    c_ignored: cover property (ign_level && pending && instr_accept);
endmodule

// *** tb/error_irq_bridge.sv ***
// far-side model: turns the active-low error output into an interrupt request
`timescale 1ns/100ps
module error_irq_bridge (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [3:0] delay,
    input  wire logic       float_error_output_n,
    output logic            intr_request_pin
);
    logic [3:0] cnt;

    // request drops as soon as the error output goes inactive again
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt <= 4'h0;
            intr_request_pin <= 1'b0;
        end else if (float_error_output_n) begin
            cnt <= 4'h0;
            intr_request_pin <= 1'b0;
        end else if (cnt < delay) begin
            cnt <= cnt + 4'h1;
        end else begin
            intr_request_pin <= 1'b1;
        end
    end
endmodule

// *** tb/test_fpu_exception_sync_freeze.sv ***
// self-checking bench of the exception sync and freeze block
`timescale 1ns/100ps
module test_fpu_exception_sync_freeze;
    logic                      core_clk, reset, ce, reg_wr, reg_rd, instr_req;
    logic                      exc_valid, exc_stack_fault, flags_clear, env_load;
    logic                      ignore_numeric_error_input, core_intr_enable;
    logic                      instr_accept, core_freeze, native_fault, fixup_apply;
    logic                      halt_instr, intr_request_pin, intr_take;
    logic                      float_error_output_n, irq;
    logic [3:0]                reg_addr, bridge_delay;
    logic [31:0]               reg_wdata, reg_rdata, instr_addr, instr_opnd, rd;
    logic [5:0]                exc_raised;
    logic [6:0]                env_flags;
    fpu_exc_pkg::instr_class_t instr_class;
    int                        errors, n_tests, m_mask, m_flags, m_native, m_ign;

    fpu_exception_sync_freeze dut (
        .core_clk, .reset, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .instr_req, .instr_class, .instr_addr, .instr_opnd, .instr_accept, .core_freeze,
        .native_fault, .exc_valid, .exc_raised, .exc_stack_fault, .fixup_apply,
        .halt_instr, .flags_clear, .env_load, .env_flags, .ignore_numeric_error_input,
        .intr_request_pin, .core_intr_enable, .intr_take, .float_error_output_n, .irq
    );

    error_irq_bridge bridge (
        .core_clk, .reset, .delay(bridge_delay), .float_error_output_n, .intr_request_pin
    );

    function automatic int pend();
        return (m_flags & ~m_mask & 'h3f) != 0;
    endfunction

    function automatic logic [31:0] status_exp(input int frz);
        return 32'(m_flags) | (pend() ? 32'h80 : 32'h0) | (frz ? 32'h100 : 32'h0);
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic done(input string s);
        $display("test %0s done", s);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    task automatic exc(input logic [5:0] r, input logic sf);
        logic [6:0]  eff;
        logic [31:0] exp;
        eff = {sf, r | {5'h0, sf}};
        exp = {30'h0, (eff[5:0] & m_mask[5:0]) != 0, (eff[5:0] & ~m_mask[5:0]) != 0};
        @(posedge core_clk);
        exc_valid <= 1'b1;
        exc_raised <= r;
        exc_stack_fault <= sf;
        @(posedge core_clk);
        exc_valid <= 1'b0;
        #1 check({30'h0, fixup_apply, halt_instr}, exp);
        m_flags = m_flags | eff;
    endtask

    task automatic flags_op(input logic ld, input logic [6:0] v);
        @(posedge core_clk);
        flags_clear <= !ld;
        env_load <= ld;
        env_flags <= v;
        @(posedge core_clk);
        flags_clear <= 1'b0;
        env_load <= 1'b0;
        m_flags = ld ? v : 0;
    endtask

    task automatic instr(input logic [1:0] c);
        logic [2:0] exp;
        int         hit;
        hit = pend() && (c == 2'h1 || c == 2'h3);
        exp = (hit && m_native) ? 3'b010 : (hit && !m_ign) ? 3'b001 : 3'b100;
        @(posedge core_clk);
        instr_req <= 1'b1;
        instr_class <= fpu_exc_pkg::instr_class_t'(c);
        instr_addr <= $urandom;
        instr_opnd <= $urandom;
        @(posedge core_clk);
        instr_req <= 1'b0;
        #1 check({29'h0, instr_accept, native_fault, core_freeze}, {29'h0, exp});
        if (exp[2] && (c == 2'h1 || c == 2'h2)) begin
            rd_reg(4'h2);
            check(rd, instr_addr);
            rd_reg(4'h3);
            check(rd, instr_opnd);
        end
    endtask

    // interrupts held off first: the frozen core must not move on its own
    task automatic release_freeze();
        int seen;
        seen = 0;
        repeat (16) begin
            @(posedge core_clk);
            #1 seen = seen + int'(intr_take === 1'b1);
        end
        check({31'h0, core_freeze}, 32'h1);
        check(32'(seen), 32'h0);
        @(posedge core_clk);
        core_intr_enable <= 1'b1;
        for (int i = 0; i < 40 && seen == 0; i++) begin
            @(posedge core_clk);
            #1 seen = int'(intr_take === 1'b1);
        end
        if (seen == 0) begin
            errors++;
            wrap_up();
        end
        check({31'h0, core_freeze}, 32'h0);
        @(posedge core_clk);
        core_intr_enable <= 1'b0;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        {reset, ce} = 2'b11;
        {reg_wr, reg_rd, instr_req, exc_valid, flags_clear, env_load} = '0;
        {ignore_numeric_error_input, core_intr_enable, bridge_delay} = '0;
        {reg_addr, reg_wdata, instr_addr, instr_opnd, exc_raised, exc_stack_fault} = '0;
        env_flags = 7'h0;
        instr_class = fpu_exc_pkg::CLASS_INTEGER;
        {errors, n_tests, m_flags, m_native, m_ign} = '0;
        m_mask = 'h3f;
        void'($urandom(32'h55cc));
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rd_reg(4'(a));
            check(rd, a == 0 ? 32'h3f : 32'h0);
        end
        check({31'h0, float_error_output_n}, 32'h1);
        // a write while the clock enable is low must leave no trace
        @(posedge core_clk);
        ce <= 1'b0;
        wr(4'h6, 32'h7);
        ce <= 1'b1;
        rd_reg(4'h6);
        check(rd, 32'h0);
        done("reset values");
        exc(6'($urandom) | 6'h20, 1'b0);
        exc(6'h01, 1'b1);
        rd_reg(4'h1);
        check(rd, status_exp(0));
        instr(2'h1);
        instr(2'h2);
        flags_op(1'b0, 7'h0);
        rd_reg(4'h1);
        check(rd, 32'h0);
        done("masked");
        wr(4'h0, 32'h0);
        m_mask = 0;
        exc(6'h00, 1'b1);
        @(posedge core_clk);
        #1 check({31'h0, float_error_output_n}, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(4'h6, 32'h7);
        rd_reg(4'h4);
        check(rd, 32'h5);
        check({31'h0, irq}, 32'h1);
        instr(2'h0);
        instr(2'h2);
        done("unmasked");
        @(posedge core_clk);
        ignore_numeric_error_input <= 1'b1;
        m_ign = 1;
        repeat (8) @(posedge core_clk);
        instr(2'h1);
        instr(2'h3);
        @(posedge core_clk);
        ignore_numeric_error_input <= 1'b0;
        m_ign = 0;
        repeat (8) @(posedge core_clk);
        done("ignore");
        for (int k = 0; k < 2; k++) begin
            @(posedge core_clk);
            bridge_delay <= k ? 4'h9 : 4'h0;
            instr(k ? 2'h3 : 2'h1);
            rd_reg(4'h1);
            check(rd, status_exp(1));
            release_freeze();
            rd_reg(4'h4);
            check(rd & 32'h2, 32'h2);
            flags_op(1'b0, 7'h0);
            flags_op(1'b1, 7'h04);
            rd_reg(4'h1);
            check(rd, status_exp(0));
        end
        flags_op(1'b0, 7'h0);
        wr(4'h5, 32'h7);
        rd_reg(4'h4);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
        done("freeze");
        wr(4'h0, 32'h100);
        m_native = 1;
        exc(6'h02, 1'b0);
        @(posedge core_clk);
        #1 check({31'h0, float_error_output_n}, 32'h1);
        instr(2'h1);
        instr(2'h3);
        flags_op(1'b0, 7'h0);
        done("native");
        wrap_up();
    end
endmodule
